// File: logic/lfa_defines.vh
// Constants for the legacy floating-point state aliasing block.
// Assumes inclusion by bare name from the logic/ folder.
`ifndef LFA_DEFINES_VH
`define LFA_DEFINES_VH

// Register byte offsets, one aligned 64-bit word each
`define LFA_OFS_CTRL 8'h00
`define LFA_OFS_STATUS 8'h08
`define LFA_OFS_DPTR 8'h10
`define LFA_OFS_IPTR 8'h18

// Reset values
`define LFA_CTRL_RESET 64'h0000_0000_0000_003f
`define LFA_TAGS_RESET 8'hff
`define LFA_MASK_RESET 6'h3f
`define LFA_TAGWORD_RESET 16'hffff

// Status word field positions
`define LFA_ST_ES 7
`define LFA_ST_BUSY 15
`define LFA_ST_TOP_LO 11
`define LFA_ST_TAG0 16
`define LFA_ST_VEC_LO 32
`define LFA_ST_RSV38 38
`define LFA_ST_RSVHI_LO 48

// Tag codes
`define LFA_TAG_NOT_EMPTY 1'b0
`define LFA_TAG_EMPTY 1'b1
`define LFA_CLS_VALID 2'h0
`define LFA_CLS_ZERO 2'h1
`define LFA_CLS_SPECIAL 2'h2
`define LFA_CLS_EMPTY 2'h3

// Aliasing patterns
`define LFA_PACKED_SE 18'h3ffff
`define LFA_VEC_EXP 17'h1003e
`define LFA_VEC_SIGN 1'b0
`define LFA_EXP_ONES 17'h1ffff
`define LFA_EXP_ZERO 17'h00000

// Native register bases
`define LFA_PACKED_BASE 2'h1
`define LFA_VEC_BASE 1'b1

`endif

// File: logic/lfa_top.v
// Legacy floating-point environment, tag word and register aliasing
// onto a 32-entry file of 82-bit native floating-point registers.
// Assumes a single 20 MHz clock and an execution core that drives one
// operation strobe per kind per cycle, synchronous to the clock.
//
// Function
// - Packed-integer ops make all tags not-empty; clear_tags makes all empty.
// - Native status reads give one-bit tags; legacy reads give classes.
// - Delayed exceptions latch operand and instruction pointers.
// - Status records invalid to stack-fault flags and summary bit.
// - Native summary read gives unmasked OR or last written value.
// - Summary written 1 raises delayed exception at next legacy fp op.
// - Inconsistent summary writes are kept; no correction applied.
// - Reserved non-zero writes fault or are stored and read back.
// - Packed registers alias native registers 8 through 15.
// - Legacy stack view of packed registers follows stack top.
// - Packed write sets sign and exponent ones, data in mantissa.
// - Packed read uses only the mantissa.
// - Mantissas are shared between fp and packed views.
// - Vector registers alias register pairs 16 to 31, low half even.
// - Vector write sets exponent 0x1003E, sign 0, halves in mantissa.
// - Vector read ignores sign and exponent.
// - Legacy 32-bit virtual addresses are zero-extended to 64 bits.
// - Both instruction sets yield the same address for one location.
//
// The address-and-strobe port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`include "lfa_defines.vh"
`default_nettype none

module lfa_top #(
  parameter ES_SUMMARY = 1,
  parameter RSV_FAULT = 0
) (
  input wire clock,
  input wire reset_n,
  input wire [7:0] reg_addr,
  input wire [63:0] reg_wdata,
  input wire reg_write,
  input wire reg_read,
  output reg [63:0] reg_rdata,
  output reg rsv_fault,
  input wire fp_wr,
  input wire fp_rd,
  input wire [4:0] fp_idx,
  input wire [81:0] fp_wdata,
  output reg [81:0] fp_rdata,
  input wire pk_wr,
  input wire pk_rd,
  input wire [2:0] pk_idx,
  input wire [63:0] pk_wdata,
  output reg [63:0] pk_rdata,
  input wire clear_tags,
  input wire vec_wr,
  input wire vec_rd,
  input wire [2:0] vec_idx,
  input wire [127:0] vec_wdata,
  output reg [127:0] vec_rdata,
  input wire st_rd,
  input wire [2:0] st_idx,
  output reg [81:0] st_rdata,
  output reg [15:0] stack_tag_word,
  input wire exc_valid,
  input wire [6:0] exc_flags,
  input wire [31:0] exc_data_ea,
  input wire [15:0] exc_data_sel,
  input wire [31:0] exc_inst_ea,
  input wire [15:0] exc_code_sel,
  input wire [10:0] exc_opcode,
  input wire lfp_issue,
  output reg delayed_exc,
  input wire addr_valid,
  input wire addr_legacy,
  input wire [63:0] addr_in,
  output reg [63:0] addr_out,
  output reg addr_out_valid
);

////////////////////////////////////////////////////////////////////////
// Functions

function [1:0] classify;
  input [81:0] r;
  input empty;
  begin
    if (empty)
      classify = `LFA_CLS_EMPTY;
    else if (r[80:64] == `LFA_EXP_ZERO && r[63:0] == 64'h0)
      classify = `LFA_CLS_ZERO;
    else if (r[80:64] == `LFA_EXP_ONES || r[80:64] == `LFA_EXP_ZERO)
      classify = `LFA_CLS_SPECIAL;
    else
      classify = `LFA_CLS_VALID;
  end
endfunction

// Stack slot to native register: rotates by the stack top
function [4:0] stack_phys;
  input [2:0] top;
  input [2:0] slot;
  reg [2:0] sum;
  begin
    sum = top + slot;
    stack_phys = {`LFA_PACKED_BASE, sum};
  end
endfunction

// Any pending flag left unmasked; shared by software and hardware paths
function unmasked_any;
  input [5:0] pend;
  input [5:0] msk;
  begin
    unmasked_any = |(pend & ~msk);
  end
endfunction

function reg_hit;
  input wr;
  input [7:0] addr;
  input [7:0] ofs;
  begin
    reg_hit = wr && addr == ofs;
  end
endfunction

////////////////////////////////////////////////////////////////////////
// State

reg [81:0] fr [0:31];
reg [5:0] mask;
reg [57:0] ctrl_rest;
reg [6:0] flags;
reg es_written;
reg [3:0] cond;
reg [2:0] top;
reg [7:0] tags;
reg [5:0] vec_flags;
reg rsv38;
reg [15:0] rsv_hi;
reg [63:0] dptr;
reg [63:0] iptr;
integer i;
integer si;
integer fi;
integer ti;

wire [4:0] pk_phys = {`LFA_PACKED_BASE, pk_idx};
wire [4:0] vec_lo = {`LFA_VEC_BASE, vec_idx, 1'b0};
wire [4:0] vec_hi = {`LFA_VEC_BASE, vec_idx, 1'b1};
wire summary = unmasked_any(flags[5:0], mask);
wire es_view = (ES_SUMMARY != 0) ? summary : es_written;
wire hw_es = exc_valid &&
  (unmasked_any(exc_flags[5:0], mask) || exc_flags[6]);

wire wr_ctrl = reg_hit(reg_write, reg_addr, `LFA_OFS_CTRL);
wire wr_stat = reg_hit(reg_write, reg_addr, `LFA_OFS_STATUS);
wire wr_dptr = reg_hit(reg_write, reg_addr, `LFA_OFS_DPTR);
wire wr_iptr = reg_hit(reg_write, reg_addr, `LFA_OFS_IPTR);

// Non-zero writes into reserved fields
wire rsv_stat = wr_stat &&
  (reg_wdata[`LFA_ST_RSV38] || |reg_wdata[63:`LFA_ST_RSVHI_LO]);
wire rsv_dptr = wr_dptr && |reg_wdata[63:48];
wire rsv_iptr = wr_iptr && |reg_wdata[63:59];
wire rsv_ctrl = wr_ctrl && |reg_wdata[63:13];
wire rsv_any = rsv_stat || rsv_dptr || rsv_iptr || rsv_ctrl;
wire drop = (RSV_FAULT != 0) && rsv_any;

reg [63:0] status_native;
reg [15:0] tag_bits;
always @* begin
  tag_bits = 16'h0;
  for (i = 0; i < 8; i = i + 1)
    tag_bits[2 * i] = tags[i];
  status_native = 64'h0;
  status_native[6:0] = flags;
  status_native[`LFA_ST_ES] = es_view;
  status_native[10:8] = cond[2:0];
  status_native[13:11] = top;
  status_native[14] = cond[3];
  status_native[`LFA_ST_BUSY] = es_view;
  status_native[31:16] = tag_bits;
  status_native[37:32] = vec_flags;
  status_native[`LFA_ST_RSV38] = rsv38;
  status_native[63:48] = rsv_hi;
end

////////////////////////////////////////////////////////////////////////
// Control and status registers

always @(posedge clock or negedge reset_n) begin
  if (!reset_n) begin
    mask <= `LFA_MASK_RESET;
    ctrl_rest <= 58'h0;
    flags <= 7'h0;
    es_written <= 1'b0;
    cond <= 4'h0;
    top <= 3'h0;
    tags <= `LFA_TAGS_RESET;
    vec_flags <= 6'h0;
    rsv38 <= 1'b0;
    rsv_hi <= 16'h0;
    dptr <= 64'h0;
    iptr <= 64'h0;
    rsv_fault <= 1'b0;
  end else begin
    rsv_fault <= drop;
    if (wr_ctrl && !drop) begin
      mask <= reg_wdata[5:0];
      ctrl_rest <= reg_wdata[63:6];
    end
    // Summary kept as written, even when it contradicts the flags
    if (wr_stat && !drop) begin
      flags <= reg_wdata[6:0];
      es_written <= reg_wdata[`LFA_ST_ES];
      cond <= {reg_wdata[14], reg_wdata[10:8]};
      top <= reg_wdata[13:11];
      for (si = 0; si < 8; si = si + 1)
        tags[si] <= reg_wdata[`LFA_ST_TAG0 + 2 * si];
      vec_flags <= reg_wdata[37:32];
      rsv38 <= reg_wdata[`LFA_ST_RSV38];
      rsv_hi <= reg_wdata[63:48];
    end
    if (wr_dptr && !drop)
      dptr <= reg_wdata;
    if (wr_iptr && !drop)
      iptr <= reg_wdata;
    // Hardware pointers win over a same-cycle software write; hardware flags are ORed into the written flags
    if (exc_valid) begin
      flags <= (wr_stat && !drop ? reg_wdata[6:0] : flags) | exc_flags;
      if (hw_es)
        es_written <= 1'b1;
      dptr <= {16'h0, exc_data_sel, exc_data_ea};
      iptr <= {5'h0, exc_opcode, exc_code_sel, exc_inst_ea};
    end
    if (clear_tags)
      tags <= {8{`LFA_TAG_EMPTY}};
    else if (pk_wr || pk_rd)
      tags <= {8{`LFA_TAG_NOT_EMPTY}};
  end
end

////////////////////////////////////////////////////////////////////////
// Register port: read data one cycle after the strobe

always @(posedge clock or negedge reset_n) begin
  if (!reset_n) begin
    reg_rdata <= 64'h0;
  end else if (reg_read) begin
    case (reg_addr)
      `LFA_OFS_CTRL: reg_rdata <= {ctrl_rest, mask};
      `LFA_OFS_STATUS: reg_rdata <= status_native;
      `LFA_OFS_DPTR: reg_rdata <= dptr;
      `LFA_OFS_IPTR: reg_rdata <= iptr;
      default: reg_rdata <= 64'h0;
    endcase
  end else begin
    reg_rdata <= 64'h0;
  end
end

////////////////////////////////////////////////////////////////////////
// Delayed exception at the next legacy floating-point instruction

always @(posedge clock or negedge reset_n) begin
  if (!reset_n)
    delayed_exc <= 1'b0;
  else
    delayed_exc <= lfp_issue && es_written;
end

////////////////////////////////////////////////////////////////////////
// Native register file with packed and vector aliasing
// Priority vector over packed over native when strobes collide.

always @(posedge clock or negedge reset_n) begin
  if (!reset_n) begin
    for (fi = 0; fi < 32; fi = fi + 1)
      fr[fi] <= 82'h0;
  end else begin
    if (fp_wr)
      fr[fp_idx] <= fp_wdata;
    if (pk_wr)
      fr[pk_phys] <= {`LFA_PACKED_SE, pk_wdata};
    if (vec_wr) begin
      fr[vec_lo] <= {`LFA_VEC_SIGN, `LFA_VEC_EXP, vec_wdata[63:0]};
      fr[vec_hi] <= {`LFA_VEC_SIGN, `LFA_VEC_EXP, vec_wdata[127:64]};
    end
  end
end

////////////////////////////////////////////////////////////////////////
// Read paths, one cycle after the strobe

always @(posedge clock or negedge reset_n) begin
  if (!reset_n) begin
    fp_rdata <= 82'h0;
    pk_rdata <= 64'h0;
    vec_rdata <= 128'h0;
    st_rdata <= 82'h0;
  end else begin
    if (fp_rd)
      fp_rdata <= fr[fp_idx];
    if (pk_rd)
      pk_rdata <= fr[pk_phys][63:0];
    if (vec_rd)
      vec_rdata <= {fr[vec_hi][63:0], fr[vec_lo][63:0]};
    if (st_rd)
      st_rdata <= fr[stack_phys(top, st_idx)];
  end
end

////////////////////////////////////////////////////////////////////////
// Legacy view of the tag word, full classification per slot
// Tag register i follows native register 8 + i, whatever the stack top.

always @(posedge clock or negedge reset_n) begin
  if (!reset_n) begin
    stack_tag_word <= `LFA_TAGWORD_RESET;
  end else begin
    for (ti = 0; ti < 8; ti = ti + 1)
      stack_tag_word[2 * ti +: 2] <=
        classify(fr[{`LFA_PACKED_BASE, ti[2:0]}], tags[ti]);
  end
end

////////////////////////////////////////////////////////////////////////
// Address extension; native addresses pass unchanged

always @(posedge clock or negedge reset_n) begin
  if (!reset_n) begin
    addr_out <= 64'h0;
    addr_out_valid <= 1'b0;
  end else begin
    addr_out_valid <= addr_valid;
    if (addr_valid) begin
      if (addr_legacy)
        addr_out <= {32'h0, addr_in[31:0]};
      else
        addr_out <= addr_in;
    end
  end
end

endmodule
`default_nettype wire

// File: testbench/lfa_checker.sv
// Port checks for lfa_top, attached by bind.
// Assumes one clock domain and lfa_defines.vh on the include path.
`timescale 1ns/1ps
`default_nettype none
`include "lfa_defines.vh"
module lfa_checker (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic [7:0] reg_addr,
  input wire logic [63:0] reg_wdata,
  input wire logic reg_write,
  input wire logic fp_wr,
  input wire logic fp_rd,
  input wire logic [4:0] fp_idx,
  input wire logic [81:0] fp_rdata,
  input wire logic pk_wr,
  input wire logic pk_rd,
  input wire logic [2:0] pk_idx,
  input wire logic clear_tags,
  input wire logic vec_wr,
  input wire logic [2:0] vec_idx,
  input wire logic [15:0] stack_tag_word,
  input wire logic lfp_issue,
  input wire logic delayed_exc,
  input wire logic addr_valid,
  input wire logic addr_legacy,
  input wire logic [63:0] addr_in,
  input wire logic [63:0] addr_out,
  input wire logic addr_out_valid
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!reset_n);
  sequence es_set_s;
    reg_write && reg_addr == `LFA_OFS_STATUS && reg_wdata[`LFA_ST_ES];
  endsequence
  // Quiet middle cycle, so no later write hides the alias pattern
  sequence pk_rd_s;
    pk_wr ##1 !(fp_wr || pk_wr) ##1
      (fp_rd && fp_idx == {2'h1, $past(pk_idx, 2)});
  endsequence
  sequence vec_rd_s;
    vec_wr ##1 !(fp_wr || vec_wr) ##1
      (fp_rd && fp_idx[4] && fp_idx[3:1] == $past(vec_idx, 2));
  endsequence
  ////////////////////////////////////////////////////////////////////////
  es_trap_a:
  assert property (es_set_s ##1 !reg_write ##1 lfp_issue |=> delayed_exc)
    else $error("summary write gave no trap");
  trap_cause_a:
  assert property (delayed_exc |-> $past(lfp_issue))
    else $error("trap without legacy issue");
  tags_clear_a:
  assert property (clear_tags ##1 !(pk_wr || pk_rd || reg_write)
    |=> stack_tag_word == 16'hffff) else $error("tags not empty");
  tags_full_a:
  assert property ((pk_wr || pk_rd) && !clear_tags && !reg_write ##1
    !(clear_tags || reg_write)
    |=> (stack_tag_word & (stack_tag_word >> 1) & 16'h5555) == 16'h0)
    else $error("empty tag after packed op");
  legacy_addr_a:
  assert property (addr_valid && addr_legacy |=> addr_out_valid &&
    addr_out == ($past(addr_in) & 64'hffff_ffff))
    else $error("legacy address not zero extended");
  native_addr_a:
  assert property (addr_valid && !addr_legacy |=> addr_out_valid &&
    addr_out == $past(addr_in)) else $error("native address altered");
  pk_alias_a:
  assert property (pk_rd_s |=> fp_rdata[81:64] == `LFA_PACKED_SE)
    else $error("packed sign and exponent wrong");
  vec_alias_a:
  assert property (vec_rd_s |=>
    fp_rdata[81:64] == {`LFA_VEC_SIGN, `LFA_VEC_EXP})
    else $error("vector sign and exponent wrong");
endmodule
bind lfa_top lfa_checker u_lfa_chk (.clock, .reset_n, .reg_addr,
  .reg_wdata, .reg_write, .fp_wr, .fp_rd, .fp_idx, .fp_rdata, .pk_wr,
  .pk_rd, .pk_idx, .clear_tags, .vec_wr, .vec_idx, .stack_tag_word,
  .lfp_issue, .delayed_exc, .addr_valid, .addr_legacy, .addr_in,
  .addr_out, .addr_out_valid);
`default_nettype wire

// File: testbench/testbench.sv
// Self-checking bench for lfa_top, driving all its ports.
// Assumes lfa_defines.vh on the include path; one 20 MHz clock.
`timescale 1ns/1ps
`default_nettype none
`include "lfa_defines.vh"
module testbench;
  localparam int RW = 12, RR = 11, FW = 10, FR = 9, PW = 8, PR = 7;
  localparam int CT = 6, VW = 5, VR = 4, SR = 3, EX = 2, LI = 1, AV = 0;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic [12:0] stb = 13'h0, seen = 13'h0;
  logic reg_write, reg_read, fp_wr, fp_rd, pk_wr, pk_rd, clear_tags;
  logic vec_wr, vec_rd, st_rd, exc_valid, lfp_issue, addr_valid;
  logic [7:0] reg_addr = 8'h00;
  logic [63:0] reg_wdata = 64'h0, pk_wdata = 64'h0, addr_in = 64'h0, d;
  logic [4:0] fp_idx = 5'h0;
  logic [81:0] fp_wdata = 82'h0, fr [8];
  logic [2:0] pk_idx = 3'h0, vec_idx = 3'h0, st_idx = 3'h0;
  logic [127:0] vec_wdata = 128'h0, v, got;
  logic [6:0] exc_flags = 7'h0;
  logic [31:0] exc_data_ea = 32'h0, exc_inst_ea = 32'h0, seed = 32'h6de6;
  logic [15:0] exc_data_sel = 16'h0, exc_code_sel = 16'h0;
  logic [10:0] exc_opcode = 11'h0;
  logic addr_legacy = 1'b0;
  wire logic [63:0] reg_rdata, pk_rdata, addr_out;
  wire logic [81:0] fp_rdata, st_rdata;
  wire logic [127:0] vec_rdata;
  wire logic [15:0] stack_tag_word;
  wire logic rsv_fault, delayed_exc, addr_out_valid;
  logic [127:0] eq [$];
  int n_fail = 0;
  int n_checks = 0;
  assign {reg_write, reg_read, fp_wr, fp_rd, pk_wr, pk_rd, clear_tags,
    vec_wr, vec_rd, st_rd, exc_valid, lfp_issue, addr_valid} = stb;
  lfa_top dut (.clock(clock), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .rsv_fault(rsv_fault), .fp_wr(fp_wr),
    .fp_rd(fp_rd), .fp_idx(fp_idx), .fp_wdata(fp_wdata),
    .fp_rdata(fp_rdata), .pk_wr(pk_wr), .pk_rd(pk_rd), .pk_idx(pk_idx),
    .pk_wdata(pk_wdata), .pk_rdata(pk_rdata), .clear_tags(clear_tags),
    .vec_wr(vec_wr), .vec_rd(vec_rd), .vec_idx(vec_idx),
    .vec_wdata(vec_wdata), .vec_rdata(vec_rdata), .st_rd(st_rd),
    .st_idx(st_idx), .st_rdata(st_rdata), .stack_tag_word(stack_tag_word),
    .exc_valid(exc_valid), .exc_flags(exc_flags),
    .exc_data_ea(exc_data_ea), .exc_data_sel(exc_data_sel),
    .exc_inst_ea(exc_inst_ea), .exc_code_sel(exc_code_sel),
    .exc_opcode(exc_opcode), .lfp_issue(lfp_issue),
    .delayed_exc(delayed_exc), .addr_valid(addr_valid),
    .addr_legacy(addr_legacy), .addr_in(addr_in), .addr_out(addr_out),
    .addr_out_valid(addr_out_valid));
  always #25 clock = ~clock;
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task check(input logic [127:0] g, input logic [127:0] e);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task note(input logic [127:0] e);
    eq.push_back(e);
  endtask
  // One strobe then an idle cycle, so no signal is set twice in a step
  task go(input int k);
    @(posedge clock);
    stb <= 13'h1 << k;
    @(posedge clock);
    stb <= 13'h0;
  endtask
  task rd(input logic [7:0] a, input logic [63:0] e);
    reg_addr <= a;
    note(e);
    go(RR);
  endtask
  task wr(input logic [7:0] a, input logic [63:0] dat);
    reg_addr <= a;
    reg_wdata <= dat;
    go(RW);
  endtask
  task finish_test();
    $display("checks %0d failures %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Results land one cycle after their strobe; one strobe at a time
  always @(posedge clock) seen <= stb;
  always @(negedge clock) begin
    if (seen[RW])
      check({127'h0, rsv_fault}, 128'h0);
    if ((seen & 13'h0a9b) != 13'h0) begin
      case (1'b1)
        seen[RR]: got = {64'h0, reg_rdata};
        seen[FR]: got = {46'h0, fp_rdata};
        seen[PR]: got = {64'h0, pk_rdata};
        seen[VR]: got = vec_rdata;
        seen[SR]: got = {46'h0, st_rdata};
        seen[LI]: got = {127'h0, delayed_exc};
        default: got = {63'h0, addr_out_valid, addr_out};
      endcase
      check(got, eq.pop_front());
    end
  end
  initial begin
    repeat (20000) @(posedge clock);
    n_fail++;
    finish_test();
  end
  initial begin
    repeat (4) @(posedge clock);
    reset_n <= 1'b1;
    rd(`LFA_OFS_STATUS, 64'h5555_0000);
    rd(`LFA_OFS_CTRL, `LFA_CTRL_RESET);
    rd(8'h20, 64'h0);
    for (int i = 0; i < 8; i++) begin
      d = {xs(), xs()};
      fr[i] = {`LFA_PACKED_SE, d};
      pk_idx <= i[2:0];
      pk_wdata <= d;
      go(PW);
      fp_idx <= {2'h1, i[2:0]};
      note(fr[i]);
      go(FR);
      note(d);
      go(PR);
    end
    rd(`LFA_OFS_STATUS, 64'h0);
    go(CT);
    rd(`LFA_OFS_STATUS, 64'h5555_0000);
    fr[5] = {1'b1, 17'h1fffe, d};
    fp_idx <= 5'd13;
    fp_wdata <= fr[5];
    go(FW);
    fr[0] = 82'h0;
    fp_idx <= 5'd8;
    fp_wdata <= 82'h0;
    go(FW);
    pk_idx <= 3'd5;
    note(d);
    go(PR);
    // Tag word lags the tags by one cycle
    repeat (2) @(negedge clock);
    check({112'h0, stack_tag_word}, 128'ha2a9);
    @(posedge clock);
    for (int j = 0; j < 8; j++) begin
      v = {xs(), xs(), xs(), xs()};
      vec_idx <= j[2:0];
      vec_wdata <= v;
      go(VW);
      fp_idx <= {1'b1, j[2:0], 1'b0};
      note({1'b0, `LFA_VEC_EXP, v[63:0]});
      go(FR);
      fp_idx <= {1'b1, j[2:0], 1'b1};
      note({1'b0, `LFA_VEC_EXP, v[127:64]});
      go(FR);
    end
    fp_idx <= 5'd30;
    fp_wdata <= {1'b1, `LFA_EXP_ONES, d};
    go(FW);
    note({v[127:64], d});
    go(VR);
    wr(`LFA_OFS_STATUS, 64'h5555_1800);
    rd(`LFA_OFS_STATUS, 64'h5555_1800);
    for (int s = 0; s < 8; s++) begin
      st_idx <= s[2:0];
      note(fr[(s + 3) % 8]);
      go(SR);
    end
    wr(`LFA_OFS_CTRL, 64'h0);
    {exc_data_ea, exc_data_sel, exc_inst_ea, exc_code_sel, exc_opcode} <=
      {32'h1234_5678, 16'h00a1, 32'h0040_1000, 16'h001b, 11'h5d9};
    exc_flags <= 7'h01;
    go(EX);
    rd(`LFA_OFS_DPTR, 64'h0000_00a1_1234_5678);
    rd(`LFA_OFS_IPTR, 64'h05d9_001b_0040_1000);
    rd(`LFA_OFS_STATUS, 64'h5555_9881);
    note(128'h1);
    go(LI);
    wr(`LFA_OFS_CTRL, 64'h3f);
    wr(`LFA_OFS_STATUS, 64'h5555_1880);
    note(128'h1);
    go(LI);
    wr(`LFA_OFS_STATUS, 64'h5555_1800);
    note(128'h0);
    go(LI);
    d = 64'ha5c3_0000_0000_0000 | {32'h0, xs()};
    wr(`LFA_OFS_DPTR, d);
    rd(`LFA_OFS_DPTR, d);
    for (int k = 0; k < 8; k++) begin
      d = {xs(), xs()};
      addr_in <= d;
      addr_legacy <= d[0];
      note({64'h1, d[0] ? {32'h0, d[31:0]} : d});
      go(AV);
    end
    repeat (3) @(posedge clock);
    if (eq.size() != 0)
      n_fail++;
    finish_test();
  end
endmodule
`default_nettype wire
